// ### src/tcp_port_ctrl.sv
module tcp_port_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // enable and supply
    input wire logic en_in,
    input wire logic power_in_good,
    // cc classifications
    input tcp_pkg::tcp_cc_type cc1_state,
    input tcp_pkg::tcp_cc_type cc2_state,
    // rate selects
    input wire logic rate_sel,
    input wire logic rate_hi_sel,
    // analog monitors
    input wire logic out_ready,
    input wire logic out_collapse,
    input wire logic cur_limited,
    input wire logic backflow_trip,
    input wire logic backflow_clear,
    input wire logic surge_trip,
    input wire logic thermal_hot,
    input wire logic thermal_cool,
    input wire logic load_heavy,
    // power controls
    output logic power_switch_on,
    output logic vconn_cc1_on,
    output logic vconn_cc2_on,
    output tcp_pkg::tcp_adv_type adv_sel,
    output logic trip_limit_sel,
    output logic limit_hi,
    // indicators
    output logic error_ind_n,
    output logic heavy_load_ind_n,
    output logic sound_adapter_ind_n,
    output logic test_adapter_ind_n,
    output logic sink_attached_ind_n,
    output logic flip_orient_ind_n
);
    import tcp_pkg::*;

    tcp_cc_if cc_bus ();

    tcp_cc_decode u_dec (
        .cc1_state(cc1_state),
        .cc2_state(cc2_state),
        .res(cc_bus.dec)
    );

    logic kill;
    logic port_enable;
    logic surge_en;
    logic allowed;
    logic guard_req;
    logic hiccup_req;
    logic hot;
    logic therm_active;
    logic ready_seen;
    logic fault_flag;
    logic next_fault;
    logic [HICCUP_CNT_W-1:0] hiccup_cnt;
    tcp_sw_state_type state;
    tcp_sw_state_type next_state;
    logic [31:0] status_word;
    logic wr_ctrl;

    // enable low acts as a reset of all port state except the control register and the apb slave
    assign kill = sys_rst | ~en_in;
    assign allowed = power_in_good & port_enable & cc_bus.sink_att;
    assign guard_req = backflow_trip | (surge_en & surge_trip);
    assign hot = therm_active | thermal_hot;
    assign hiccup_req = (cur_limited & out_collapse) | hot;

    // switch sequencing
    always_comb begin
        next_state = state;
        case (state)
            SW_OFF: begin
                if (allowed) begin
                    next_state = SW_PRECHECK;
                end
            end
            SW_PRECHECK: begin
                if (!allowed) begin
                    next_state = SW_OFF;
                end else if (hot) begin
                    next_state = SW_HICCUP;
                end else if (!guard_req) begin
                    // output above input at enable keeps the switch open
                    next_state = SW_ON;
                end
            end
            SW_ON: begin
                if (!allowed) begin
                    next_state = SW_OFF;
                end else if (guard_req) begin
                    next_state = SW_GUARD;
                end else if (hiccup_req) begin
                    next_state = SW_HICCUP;
                end
            end
            SW_GUARD: begin
                if (!allowed) begin
                    next_state = SW_OFF;
                end else if (hot) begin
                    next_state = SW_HICCUP;
                end else if (backflow_clear && !guard_req) begin
                    next_state = SW_ON;
                end
            end
            SW_HICCUP: begin
                if (!allowed) begin
                    next_state = SW_OFF;
                end else if (hiccup_cnt == '0 && !hot) begin
                    // retry goes through the pre-check again
                    next_state = SW_PRECHECK;
                end
            end
            default: begin
                next_state = SW_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (kill) begin
            state <= SW_OFF;
            power_switch_on <= 1'b0;
        end else begin
            state <= next_state;
            power_switch_on <= (next_state == SW_ON);
        end
    end

    // hiccup off timer
    always_ff @(posedge clk) begin
        if (kill) begin
            hiccup_cnt <= '0;
        end else if (next_state == SW_HICCUP && state != SW_HICCUP) begin
            hiccup_cnt <= HICCUP_CNT_W'(HICCUP_OFF_CYC - 1);
        end else if (hiccup_cnt != '0) begin
            hiccup_cnt <= hiccup_cnt - 1'b1;
        end
    end

    // thermal latch with hysteresis; a new hot reading beats the cool one
    always_ff @(posedge clk) begin
        if (kill) begin
            therm_active <= 1'b0;
        end else if (thermal_hot) begin
            therm_active <= 1'b1;
        end else if (thermal_cool) begin
            therm_active <= 1'b0;
        end
    end

    // output ready seen in the current on period
    always_ff @(posedge clk) begin
        if (kill || state != SW_ON) begin
            ready_seen <= 1'b0;
        end else if (out_ready) begin
            ready_seen <= 1'b1;
        end
    end

    // current limit level: fold until up, trip after, fold on collapse
    always_ff @(posedge clk) begin
        if (kill || state != SW_ON || out_collapse) begin
            trip_limit_sel <= 1'b0;
        end else if (out_ready) begin
            trip_limit_sel <= 1'b1;
        end
    end

    // fault: set wins over clear, so a fresh event is never lost
    always_comb begin
        next_fault = fault_flag;
        if (state == SW_ON && out_ready && !cur_limited && !out_collapse && !hot) begin
            next_fault = 1'b0;
        end
        if ((state == SW_ON && ready_seen && cur_limited && out_collapse) || hot) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (kill) begin
            fault_flag <= 1'b0;
            error_ind_n <= 1'b1;
        end else begin
            fault_flag <= next_fault;
            error_ind_n <= ~next_fault;
        end
    end

    // advertisement and limit decode
    always_ff @(posedge clk) begin
        if (kill) begin
            adv_sel <= ADV_DEFAULT;
            limit_hi <= 1'b0;
        end else if (!rate_sel) begin
            adv_sel <= ADV_DEFAULT;
            limit_hi <= 1'b0;
        end else if (!rate_hi_sel) begin
            adv_sel <= ADV_1A5;
            limit_hi <= 1'b0;
        end else begin
            adv_sel <= ADV_3A;
            limit_hi <= 1'b1;
        end
    end

    // vconn and indicators; the pad turns a low into an open-drain pull
    always_ff @(posedge clk) begin
        if (kill) begin
            vconn_cc1_on <= 1'b0;
            vconn_cc2_on <= 1'b0;
            heavy_load_ind_n <= 1'b1;
            sound_adapter_ind_n <= 1'b1;
            test_adapter_ind_n <= 1'b1;
            sink_attached_ind_n <= 1'b1;
            flip_orient_ind_n <= 1'b1;
        end else begin
            vconn_cc1_on <= power_in_good & port_enable & cc_bus.vconn1;
            vconn_cc2_on <= power_in_good & port_enable & cc_bus.vconn2;
            // load detect is meaningless outside 3A mode
            heavy_load_ind_n <= ~(rate_sel & rate_hi_sel & load_heavy & power_switch_on);
            sound_adapter_ind_n <= ~cc_bus.audio_acc;
            test_adapter_ind_n <= ~cc_bus.debug_acc;
            sink_attached_ind_n <= ~cc_bus.sink_att;
            flip_orient_ind_n <= ~cc_bus.flipped;
        end
    end

    // apb slave: zero wait states, data prepared in the setup cycle
    always_comb begin
        status_word = '0;
        status_word[ST_STATE_LSB +: 3] = state;
        status_word[ST_FAULT_BIT] = fault_flag;
        status_word[ST_THERM_BIT] = therm_active;
        status_word[ST_SINK_BIT] = cc_bus.sink_att;
        status_word[ST_FLIP_BIT] = cc_bus.flipped;
        status_word[ST_DEBUG_BIT] = cc_bus.debug_acc;
        status_word[ST_AUDIO_BIT] = cc_bus.audio_acc;
        status_word[ST_TRIP_BIT] = trip_limit_sel;
        status_word[ST_VCONN1_BIT] = vconn_cc1_on;
        status_word[ST_VCONN2_BIT] = vconn_cc2_on;
        status_word[ST_HEAVY_BIT] = ~heavy_load_ind_n;
    end

    assign wr_ctrl = psel & penable & pready & pwrite & (paddr == CTRL_OFF);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= (paddr != CTRL_OFF) && (paddr != STATUS_OFF);
                if (pwrite) begin
                    prdata <= '0;
                end else if (paddr == CTRL_OFF) begin
                    prdata <= {30'h0, surge_en, port_enable};
                end else if (paddr == STATUS_OFF) begin
                    prdata <= status_word;
                end else begin
                    prdata <= '0;
                end
            end
        end
    end

    // control register survives enable low so software setup is kept
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_enable <= CTRL_RESET[CTRL_PORT_EN_BIT];
            surge_en <= CTRL_RESET[CTRL_SURGE_EN_BIT];
        end else if (wr_ctrl) begin
            port_enable <= pwdata[CTRL_PORT_EN_BIT];
            surge_en <= pwdata[CTRL_SURGE_EN_BIT];
        end
    end

    property p_en_off;
        @(posedge clk) disable iff (sys_rst) !en_in |=> !power_switch_on && state == SW_OFF;
    endproperty
    a_en_off: assert property (p_en_off) else $error("switch on while disabled");

    property p_supply;
        @(posedge clk) disable iff (sys_rst) power_switch_on |-> $past(power_in_good && cc_bus.sink_att);
    endproperty
    a_supply: assert property (p_supply) else $error("switch on without supply or sink");

    property p_vconn;
        @(posedge clk) disable iff (sys_rst)
            vconn_cc2_on |-> $past(cc1_state == CC_RD && cc2_state == CC_RA) && !vconn_cc1_on;
    endproperty
    a_vconn: assert property (p_vconn) else $error("vconn on wrong line");

    property p_backflow;
        @(posedge clk) disable iff (kill) backflow_trip |=> !power_switch_on;
    endproperty
    a_backflow: assert property (p_backflow) else $error("switch stayed on under backflow");

    property p_surge;
        @(posedge clk) disable iff (kill) surge_en && surge_trip |=> !power_switch_on;
    endproperty
    a_surge: assert property (p_surge) else $error("switch stayed on under surge");

    property p_thermal;
        @(posedge clk) disable iff (kill) thermal_hot |=> !power_switch_on && !error_ind_n;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal did not open switch or flag error");

    property p_precheck;
        @(posedge clk) disable iff (kill) state == SW_PRECHECK && backflow_trip |=> state != SW_ON;
    endproperty
    a_precheck: assert property (p_precheck) else $error("switch closed with output above input");

    property p_hiccup_wait;
        @(posedge clk) disable iff (kill)
            state == SW_ON && next_state == SW_HICCUP |=> !power_switch_on [*8];
    endproperty
    a_hiccup_wait: assert property (p_hiccup_wait) else $error("hiccup off time too short");

    property p_heavy;
        @(posedge clk) disable iff (sys_rst) !heavy_load_ind_n |-> $past(rate_sel && rate_hi_sel && load_heavy);
    endproperty
    a_heavy: assert property (p_heavy) else $error("heavy load outside 3A mode");

    property p_audio;
        @(posedge clk) disable iff (kill)
            cc1_state == CC_RA && cc2_state == CC_RA |=> !sound_adapter_ind_n && sink_attached_ind_n;
    endproperty
    a_audio: assert property (p_audio) else $error("audio accessory not flagged");
endmodule : tcp_port_ctrl

// ### src/tcp_pkg.sv
package tcp_pkg;
    // classification of one cc line from the analog comparators
    typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RA} tcp_cc_type;
    // current advertisement placed on the cc line
    typedef enum logic [1:0] {ADV_DEFAULT, ADV_1A5, ADV_3A} tcp_adv_type;
    // power switch sequencing
    typedef enum logic [2:0] {SW_OFF, SW_PRECHECK, SW_ON, SW_GUARD, SW_HICCUP} tcp_sw_state_type;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;

    // control register fields and value after reset
    localparam int CTRL_PORT_EN_BIT = 0;
    localparam int CTRL_SURGE_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_THERM_BIT = 4;
    localparam int ST_SINK_BIT = 5;
    localparam int ST_FLIP_BIT = 6;
    localparam int ST_DEBUG_BIT = 7;
    localparam int ST_AUDIO_BIT = 8;
    localparam int ST_TRIP_BIT = 9;
    localparam int ST_VCONN1_BIT = 10;
    localparam int ST_VCONN2_BIT = 11;
    localparam int ST_HEAVY_BIT = 12;

    // hiccup off time and its cycle count at 100 mhz
    localparam int CLK_PERIOD_NS = 10;
    localparam int HICCUP_OFF_NS = 20000;
    localparam int HICCUP_OFF_CYC = (HICCUP_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HICCUP_CNT_W = 12;
endpackage : tcp_pkg

// ### src/tcp_cc_if.sv
interface tcp_cc_if;
    logic sink_att;
    logic debug_acc;
    logic audio_acc;
    logic flipped;
    logic vconn1;
    logic vconn2;

    modport dec (
        output sink_att, debug_acc, audio_acc, flipped, vconn1, vconn2
    );
    modport ctl (
        input sink_att, debug_acc, audio_acc, flipped, vconn1, vconn2
    );
endinterface : tcp_cc_if

// ### src/tcp_cc_decode.sv
module tcp_cc_decode (
    // cc classifications
    input tcp_pkg::tcp_cc_type cc1_state,
    input tcp_pkg::tcp_cc_type cc2_state,
    // decoded attachment
    tcp_cc_if.dec res
);
    import tcp_pkg::*;

    logic rd1;
    logic rd2;
    logic ra1;
    logic ra2;

    assign rd1 = (cc1_state == CC_RD);
    assign rd2 = (cc2_state == CC_RD);
    assign ra1 = (cc1_state == CC_RA);
    assign ra2 = (cc2_state == CC_RA);

    // any rd means a sink; ra alone is a cable or audio and gets no vbus
    assign res.sink_att = rd1 | rd2;
    assign res.debug_acc = rd1 & rd2;
    assign res.audio_acc = ra1 & ra2;
    // sink found only on cc2 means the plug is reversed
    assign res.flipped = rd2 & ~rd1;
    // vconn goes to the line that carries ra
    assign res.vconn1 = ra1 & rd2;
    assign res.vconn2 = rd1 & ra2;
endmodule : tcp_cc_decode

// ### bench/tcp_sink_model.sv
// far-side sink, cable or accessory: terminations plus a simple output ramp
module tcp_sink_model (
    // clock
    input wire logic clk,
    // terminations the scenario plugs in
    input tcp_pkg::tcp_cc_type cc1_term,
    input tcp_pkg::tcp_cc_type cc2_term,
    input wire logic heavy_draw,
    input wire logic [3:0] ramp_cyc,
    // seen from the port
    input wire logic power_switch_on,
    output tcp_pkg::tcp_cc_type cc1_state,
    output tcp_pkg::tcp_cc_type cc2_state,
    output logic out_ready,
    output logic load_heavy
);
    import tcp_pkg::*;

    logic [3:0] ramp_cnt;

    // a slow ramp keeps the output unready for a while, so the fold limit phase can be seen
    always_ff @(posedge clk) begin
        if (!power_switch_on) begin
            ramp_cnt <= 4'h0;
        end else if (ramp_cnt != ramp_cyc) begin
            ramp_cnt <= ramp_cnt + 4'h1;
        end
    end

    assign cc1_state = cc1_term;
    assign cc2_state = cc2_term;
    assign out_ready = power_switch_on && (ramp_cnt == ramp_cyc);
    assign load_heavy = power_switch_on && heavy_draw;
endmodule : tcp_sink_model

// ### bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcp_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic en_in, power_in_good, rate_sel, rate_hi_sel, out_ready, out_collapse, cur_limited;
    logic backflow_trip, backflow_clear, surge_trip, thermal_hot, thermal_cool, load_heavy;
    logic power_switch_on, vconn_cc1_on, vconn_cc2_on, trip_limit_sel, limit_hi, heavy_draw, errv;
    logic error_ind_n, heavy_load_ind_n, sound_adapter_ind_n, test_adapter_ind_n;
    logic sink_attached_ind_n, flip_orient_ind_n;
    logic [3:0] ramp_cyc;
    tcp_cc_type cc1_state, cc2_state, cc1_term, cc2_term;
    tcp_adv_type adv_sel;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    localparam tcp_cc_type T1 [9] = '{CC_OPEN, CC_RD, CC_OPEN, CC_OPEN, CC_RA, CC_RD, CC_RA, CC_RD, CC_RA};
    localparam tcp_cc_type T2 [9] = '{CC_OPEN, CC_OPEN, CC_RD, CC_RA, CC_OPEN, CC_RA, CC_RD, CC_RD, CC_RA};
    // one bit per table row: bus power, vconn1, vconn2, audio, debug, flipped
    localparam logic [8:0] VB = 9'h0e6, V1 = 9'h040, V2 = 9'h020, AU = 9'h100, DB = 9'h080, FL = 9'h044;

    tcp_port_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .en_in(en_in),
        .power_in_good(power_in_good), .cc1_state(cc1_state), .cc2_state(cc2_state), .rate_sel(rate_sel),
        .rate_hi_sel(rate_hi_sel), .out_ready(out_ready), .out_collapse(out_collapse), .cur_limited(cur_limited),
        .backflow_trip(backflow_trip), .backflow_clear(backflow_clear), .surge_trip(surge_trip),
        .thermal_hot(thermal_hot), .thermal_cool(thermal_cool), .load_heavy(load_heavy),
        .power_switch_on(power_switch_on), .vconn_cc1_on(vconn_cc1_on), .vconn_cc2_on(vconn_cc2_on),
        .adv_sel(adv_sel), .trip_limit_sel(trip_limit_sel), .limit_hi(limit_hi), .error_ind_n(error_ind_n),
        .heavy_load_ind_n(heavy_load_ind_n), .sound_adapter_ind_n(sound_adapter_ind_n),
        .test_adapter_ind_n(test_adapter_ind_n), .sink_attached_ind_n(sink_attached_ind_n),
        .flip_orient_ind_n(flip_orient_ind_n));

    tcp_sink_model u_sink (.clk(clk), .cc1_term(cc1_term), .cc2_term(cc2_term), .heavy_draw(heavy_draw),
        .ramp_cyc(ramp_cyc), .power_switch_on(power_switch_on), .cc1_state(cc1_state), .cc2_state(cc2_state),
        .out_ready(out_ready), .load_heavy(load_heavy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    // the whole run needs under 8000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 1'b1, pready);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                input logic experr);
        apb(a, 1'b0, 32'h0);
        chk(nm, exp, rdv & mask);
        chk("pslverr", experr, errv);
    endtask : rd_chk

    task wait_on;
        n = 0;
        while (power_switch_on !== 1'b1 && n < 2600) begin
            @(posedge clk);
            n++;
        end
        chk("switch back on", 1'b1, power_switch_on);
    endtask : wait_on

    task settle(input int c, input logic sw);
        repeat (c) @(posedge clk);
        chk("switch", sw, power_switch_on);
    endtask : settle

    initial begin
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        en_in = 1'b1; power_in_good = 1'b1; rate_sel = 1'b0; rate_hi_sel = 1'b0; out_collapse = 1'b0;
        cur_limited = 1'b0; backflow_trip = 1'b0; backflow_clear = 1'b0; surge_trip = 1'b0;
        thermal_hot = 1'b0; thermal_cool = 1'b0; heavy_draw = 1'b0; ramp_cyc = 4'h2;
        cc1_term = CC_OPEN; cc2_term = CC_OPEN;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk("ctrl", CTRL_OFF, 32'hffff_ffff, 32'h3, 1'b0);
        rd_chk("status", STATUS_OFF, 32'hffff_ffff, 32'h0, 1'b0);
        rd_chk("unmapped", 8'h08, 32'hffff_ffff, 32'h0, 1'b1);
        apb(STATUS_OFF, 1'b1, 32'h1f);
        rd_chk("status ro", STATUS_OFF, 32'hffff_ffff, 32'h0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            cc1_term <= T1[i];
            cc2_term <= T2[i];
            settle(4, VB[i]);
            chk("vconn1", V1[i], vconn_cc1_on);
            chk("vconn2", V2[i], vconn_cc2_on);
            chk("audio", !AU[i], sound_adapter_ind_n);
            chk("debug", !DB[i], test_adapter_ind_n);
            chk("sink", !VB[i], sink_attached_ind_n);
            chk("flip", !FL[i], flip_orient_ind_n);
            rd_chk("status", STATUS_OFF, 32'h0120, (32'(VB[i]) << ST_SINK_BIT) | (32'(AU[i]) << ST_AUDIO_BIT),
                   1'b0);
            cc1_term <= CC_OPEN;
            cc2_term <= CC_OPEN;
            repeat (3) @(posedge clk);
        end
        cc1_term <= CC_RD;
        heavy_draw <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            rate_sel <= r[1];
            rate_hi_sel <= r[0];
            settle(4, 1'b1);
            chk("adv", r[1] ? (r[0] ? ADV_3A : ADV_1A5) : ADV_DEFAULT, adv_sel);
            chk("limit hi", r == 3, limit_hi);
            chk("heavy", r != 3, heavy_load_ind_n);
        end
        heavy_draw <= 1'b0;
        ramp_cyc <= 4'h8;
        chk("trip sel", 1'b1, trip_limit_sel);
        // collapse under limit once ready: hiccup and fault
        out_collapse <= 1'b1;
        cur_limited <= 1'b1;
        settle(2, 1'b0);
        chk("error", 1'b0, error_ind_n);
        chk("trip sel", 1'b0, trip_limit_sel);
        out_collapse <= 1'b0;
        cur_limited <= 1'b0;
        wait_on();
        chk("hiccup off time", 1'b1, n >= HICCUP_OFF_CYC - 4);
        chk("error held", 1'b0, error_ind_n);
        chk("fold sel", 1'b0, trip_limit_sel);
        repeat (14) @(posedge clk);
        chk("error clear", 1'b1, error_ind_n);
        chk("trip sel", 1'b1, trip_limit_sel);
        backflow_trip <= 1'b1;
        settle(2, 1'b0);
        backflow_trip <= 1'b0;
        backflow_clear <= 1'b1;
        settle(4, 1'b1);
        // a surge leaves the output at input level, so the backflow clear comparator stays high
        surge_trip <= 1'b1;
        settle(2, 1'b0);
        surge_trip <= 1'b0;
        settle(5, 1'b1);
        thermal_hot <= 1'b1;
        settle(2, 1'b0);
        chk("error hot", 1'b0, error_ind_n);
        thermal_hot <= 1'b0;
        settle(20, 1'b0);
        thermal_cool <= 1'b1;
        wait_on();
        thermal_cool <= 1'b0;
        repeat (14) @(posedge clk);
        chk("error clear", 1'b1, error_ind_n);
        power_in_good <= 1'b0;
        settle(2, 1'b0);
        power_in_good <= 1'b1;
        settle(4, 1'b1);
        apb(CTRL_OFF, 1'b1, 32'h2);
        rd_chk("ctrl", CTRL_OFF, 32'h3, 32'h2, 1'b0);
        settle(1, 1'b0);
        apb(CTRL_OFF, 1'b1, 32'h3);
        settle(4, 1'b1);
        en_in <= 1'b0;
        settle(2, 1'b0);
        chk("sink off", 1'b1, sink_attached_ind_n);
        en_in <= 1'b1;
        settle(4, 1'b1);
        // output already above input when attaching: pre-check keeps the switch open
        cc1_term <= CC_OPEN;
        repeat (3) @(posedge clk);
        backflow_trip <= 1'b1;
        backflow_clear <= 1'b0;
        cc1_term <= CC_RD;
        settle(6, 1'b0);
        backflow_trip <= 1'b0;
        backflow_clear <= 1'b1;
        settle(6, 1'b1);
        final_report();
    end
endmodule : tb
